//--- hw/cfg_preload_pkg.sv
`default_nettype none
package cfg_preload_pkg;
   // Image word addresses (byte addresses into the image, 16-bit words).
   localparam logic [7:0] ADDR_SIG = 8'h00;
   localparam logic [7:0] ADDR_VEN = 8'h02;
   localparam logic [7:0] ADDR_DEV = 8'h04;
   localparam logic [7:0] ADDR_OPT_A = 8'h06;
   localparam logic [7:0] ADDR_SSVEN = 8'h08;
   localparam logic [7:0] ADDR_SSID = 8'h0a;
   localparam logic [7:0] ADDR_OPT_B = 8'h0c;
   localparam logic [7:0] ADDR_STEP = 8'h02;
   // Expected signature; the value is arbitrary.
   localparam logic [15:0] SIGNATURE_DEFAULT = 16'h5a3c;
   localparam int NUM_PORTS = 3;
   // Hardware defaults of the loaded fields.
   localparam logic [15:0] ID_RESET = 16'h0000;
   localparam logic [15:0] OPT_RESET = 16'h0000;
   // Field positions inside option word 06h.
   localparam int A_VC = 0;
   localparam int A_L0S_LO = 1;
   localparam int A_L1_LO = 4;
   localparam int A_NOORD_EGR = 8;
   localparam int A_NOORD_TAG = 9;
   localparam int A_SAF = 10;
   localparam int A_CT_LO = 11;
   localparam int A_ARB = 13;
   localparam int A_CRED = 14;
   localparam int A_INTA = 15;
   // Field positions inside option word 0Ch.
   localparam int B_MPS_LO = 0;
   localparam int B_ASPM_LO = 2;
   localparam int B_RBER = 4;
   localparam int B_MSI_DIS = 5;
   localparam int B_PAR_DIS = 6;
   localparam int B_PM_DIS = 7;
   localparam int B_PPNP = 8;
   localparam int B_LBN = 9;
   localparam int B_FREEZE = 10;
   localparam int B_SOF = 11;
   localparam int B_SDN = 12;
   localparam int B_PMDS = 13;
   localparam int B_LTR = 14;
   localparam int B_4KB = 15;
   // Target field positions in the port registers.
   localparam int R144_VC = 0;
   localparam int RCC_ASPM_LO = 10;
   localparam int RCC_L0S_LO = 12;
   localparam int RCC_L1_LO = 15;
   localparam int RCC_SDN = 19;
   localparam int RCC_LBN = 21;
   localparam int R74_SAF = 0;
   localparam int R74_CT_LO = 1;
   localparam int R74_ARB = 3;
   localparam int R74_CRED = 4;
   localparam int R74_NOORD_EGR = 5;
   localparam int R74_NOORD_TAG = 6;
   localparam int R74_PAR_DIS = 15;
   localparam int R3C_INTA = 8;
   localparam int RC4_MPS_LO = 0;
   localparam int RC4_RBER = 15;
   localparam int R70_PM_DIS = 13;
   localparam int R70_MSI_DIS = 14;
   localparam int R8C_SOF = 0;
   localparam int R8C_PMDS = 1;
   localparam int R8C_4KB = 3;
   localparam int R8C_PPNP = 5;
   localparam int R8C_FREEZE = 6;
   localparam int RE4_LTR = 12;
   localparam int FIRST_HOST_PORT = 1;
   typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_DONE} ld_state_t;
endpackage
`default_nettype wire

//--- hw/eeprom_config_preload.sv
// Notes on behaviour
// RULE1: Image word 00h must hold the fixed signature marking a valid image.
// RULE2: Word 06h bit 0 goes to offset 144h bit 0, ports 0 to 2.
// RULE3: Word 06h bits 3:1 go to CCh bits 14:12, L0s exit latency.
// RULE4: Word 06h bits 6:4 go to CCh bits 17:15, L1 exit latency.
// RULE5: Word 06h bits 8 and 9 go to 74h bits 5 and 6.
// RULE6: Word 06h bit 10 to 74h bit 0, bits 12:11 to 74h bits 2:1.
// RULE7: Word 06h bit 13 to 74h bit 3, bit 14 to 74h bit 4.
// RULE8: Word 06h bit 15 to 3Ch bit 8 on ports 1 and 2 only.
// RULE9: Word 0Ch bits 1:0 go to C4h bits 1:0, max payload size.
// RULE10: Word 0Ch bits 3:2 go to CCh bits 11:10, ASPM support.
// RULE11: Word 0Ch bit 4 goes to C4h bit 15, role-based error reporting.
// RULE12: Word 0Ch bit 5 goes to 70h bit 14, MSI capability removed.
// RULE13: Word 0Ch bit 6 goes to 74h bit 15, compliance parity disabled.
// RULE14: Word 0Ch bit 7 goes to 70h bit 13, PM capability removed.
// RULE15: Word 0Ch bit 8 goes to 8Ch bit 5, posted passes non-posted.
// RULE16: Word 0Ch bit 9 goes to CCh bit 21 on ports 1 and 2 only.
// RULE17: Word 0Ch bit 10 goes to 8Ch bit 6, ordering frozen.
// RULE18: Word 0Ch bit 11 goes to 8Ch bit 0, start-of-frame latency select.
// RULE19: Word 0Ch bit 12 goes to CCh bit 19, surprise-down reporting.
// RULE20: Word 0Ch bit 13 goes to 8Ch bit 1, PM data select writable.
// RULE21: Word 0Ch bit 14 goes to E4h bit 12, LTR capability.
// RULE22: Word 0Ch bit 15 goes to 8Ch bit 3, 4KB boundary check.
// RULE23: Copy words 02h to 0Ah into IDs, only when the signature matches.
// RULE24: Finish loading before host config access; defaults held until then.
`default_nettype none
module eeprom_config_preload #(
   parameter logic [15:0] SIGNATURE = cfg_preload_pkg::SIGNATURE_DEFAULT
) (
   input wire logic mclk,
   input wire logic nrst,
   output logic rd_req,
   output logic [7:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   output logic load_busy,
   output logic load_done,
   output logic image_valid,
   output logic cfg_access_enable,
   output logic [15:0] vendor_id,
   output logic [15:0] device_id,
   output logic [15:0] subsys_vendor_id,
   output logic [15:0] subsys_id,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] ext_vc_count,
   output logic [cfg_preload_pkg::NUM_PORTS*3-1:0] l0s_exit_latency,
   output logic [cfg_preload_pkg::NUM_PORTS*3-1:0] l1_exit_latency,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] no_order_egress,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] no_order_tag,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] store_forward,
   output logic [cfg_preload_pkg::NUM_PORTS*2-1:0] cut_through_threshold,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] port_arb_mode,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] credit_update_mode,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] inta_pin,
   output logic [cfg_preload_pkg::NUM_PORTS*2-1:0] max_payload_support,
   output logic [cfg_preload_pkg::NUM_PORTS*2-1:0] aspm_support,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] role_err_report,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] msi_cap_disable,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] compliance_parity_disable,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] pm_cap_disable,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] posted_pass_nonposted_enable,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] link_bw_notify_cap,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] ordering_freeze,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] tx_frame_start_latency_select,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] surprise_down_cap,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] pm_data_select_writable,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] ltr_cap_enable,
   output logic [cfg_preload_pkg::NUM_PORTS-1:0] boundary_4kb_check
);
   import cfg_preload_pkg::*;

   // All state of the loader in one record, published outputs included.
   typedef struct packed {
      // Sequencer and status.
      ld_state_t st;
      logic [7:0] addr;
      logic req;
      logic busy;
      logic done;
      logic valid;
      // Words held until the image is complete.
      logic [15:0] ven;
      logic [15:0] dev;
      logic [15:0] ssven;
      logic [15:0] ssid;
      logic [15:0] opt_a;
      // Published identifiers.
      logic [15:0] ven_o;
      logic [15:0] dev_o;
      logic [15:0] ssven_o;
      logic [15:0] ssid_o;
      // Published per-port fields.
      logic [NUM_PORTS-1:0] vc;
      logic [NUM_PORTS*3-1:0] l0s;
      logic [NUM_PORTS*3-1:0] l1;
      logic [NUM_PORTS-1:0] noe;
      logic [NUM_PORTS-1:0] notag;
      logic [NUM_PORTS-1:0] saf;
      logic [NUM_PORTS*2-1:0] ct;
      logic [NUM_PORTS-1:0] arb;
      logic [NUM_PORTS-1:0] cred;
      logic [NUM_PORTS-1:0] inta;
      logic [NUM_PORTS*2-1:0] mps;
      logic [NUM_PORTS*2-1:0] aspm;
      logic [NUM_PORTS-1:0] rber;
      logic [NUM_PORTS-1:0] msi;
      logic [NUM_PORTS-1:0] par;
      logic [NUM_PORTS-1:0] pm;
      logic [NUM_PORTS-1:0] ppnp;
      logic [NUM_PORTS-1:0] lbn;
      logic [NUM_PORTS-1:0] frz;
      logic [NUM_PORTS-1:0] sof;
      logic [NUM_PORTS-1:0] sdn;
      logic [NUM_PORTS-1:0] pmds;
      logic [NUM_PORTS-1:0] ltr;
      logic [NUM_PORTS-1:0] b4k;
   } ld_t;

   ld_t s_r;
   ld_t s_nxt;

   // Per-port view of the option words; word 0Ch is taken straight off rd_data.
   logic [NUM_PORTS-1:0] vc_img;
   logic [NUM_PORTS*3-1:0] l0s_img;
   logic [NUM_PORTS*3-1:0] l1_img;
   logic [NUM_PORTS-1:0] noe_img;
   logic [NUM_PORTS-1:0] notag_img;
   logic [NUM_PORTS-1:0] saf_img;
   logic [NUM_PORTS*2-1:0] ct_img;
   logic [NUM_PORTS-1:0] arb_img;
   logic [NUM_PORTS-1:0] cred_img;
   logic [NUM_PORTS-1:0] inta_img;
   // Fields that come from word 0Ch.
   logic [NUM_PORTS*2-1:0] mps_img;
   logic [NUM_PORTS*2-1:0] aspm_img;
   logic [NUM_PORTS-1:0] rber_img;
   logic [NUM_PORTS-1:0] msi_img;
   logic [NUM_PORTS-1:0] par_img;
   logic [NUM_PORTS-1:0] pm_img;
   logic [NUM_PORTS-1:0] ppnp_img;
   logic [NUM_PORTS-1:0] lbn_img;
   logic [NUM_PORTS-1:0] frz_img;
   logic [NUM_PORTS-1:0] sof_img;
   logic [NUM_PORTS-1:0] sdn_img;
   logic [NUM_PORTS-1:0] pmds_img;
   logic [NUM_PORTS-1:0] ltr_img;
   logic [NUM_PORTS-1:0] b4k_img;

   // Sequencer: reads words 00h to 0Ch one at a time, stops early on a bad signature.
   always_comb begin
      s_nxt = s_r;
      s_nxt.req = 1'b0;
      case (s_r.st)
         ST_IDLE: begin
            s_nxt.st = ST_REQ;
            s_nxt.addr = ADDR_SIG;
            s_nxt.busy = 1'b1;
         end
         ST_REQ: begin
            s_nxt.req = 1'b1;
            s_nxt.st = ST_WAIT;
         end
         ST_WAIT: begin
            if (rd_valid) begin
               s_nxt.st = ST_REQ;
               s_nxt.addr = s_r.addr + ADDR_STEP;
               case (s_r.addr)
                  ADDR_SIG: begin
                     if (rd_data != SIGNATURE) begin // RULE1
                        s_nxt.st = ST_DONE;
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                     end
                  end
                  ADDR_VEN: s_nxt.ven = rd_data; // RULE23
                  ADDR_DEV: s_nxt.dev = rd_data; // RULE23
                  ADDR_OPT_A: s_nxt.opt_a = rd_data;
                  ADDR_SSVEN: s_nxt.ssven = rd_data; // RULE23
                  ADDR_SSID: s_nxt.ssid = rd_data; // RULE23
                  ADDR_OPT_B: begin
                     s_nxt.st = ST_DONE;
                     s_nxt.busy = 1'b0;
                     s_nxt.done = 1'b1; // RULE24
                     s_nxt.valid = 1'b1; // RULE23
                     // Publish everything at once, so the host never sees a half-loaded image.
                     s_nxt.ven_o = s_r.ven; // RULE23
                     s_nxt.dev_o = s_r.dev; // RULE23
                     s_nxt.ssven_o = s_r.ssven; // RULE23
                     s_nxt.ssid_o = s_r.ssid; // RULE23
                     // Fields of word 06h.
                     s_nxt.vc = vc_img; // RULE2
                     s_nxt.l0s = l0s_img; // RULE3
                     s_nxt.l1 = l1_img; // RULE4
                     s_nxt.noe = noe_img; // RULE5
                     s_nxt.notag = notag_img; // RULE5
                     s_nxt.saf = saf_img; // RULE6
                     s_nxt.ct = ct_img; // RULE6
                     s_nxt.arb = arb_img; // RULE7
                     s_nxt.cred = cred_img; // RULE7
                     s_nxt.inta = inta_img; // RULE8
                     // Fields of word 0Ch, taken in the cycle it arrives.
                     s_nxt.mps = mps_img; // RULE9
                     s_nxt.aspm = aspm_img; // RULE10
                     s_nxt.rber = rber_img; // RULE11
                     s_nxt.msi = msi_img; // RULE12
                     s_nxt.par = par_img; // RULE13
                     s_nxt.pm = pm_img; // RULE14
                     s_nxt.ppnp = ppnp_img; // RULE15
                     s_nxt.lbn = lbn_img; // RULE16
                     s_nxt.frz = frz_img; // RULE17
                     s_nxt.sof = sof_img; // RULE18
                     s_nxt.sdn = sdn_img; // RULE19
                     s_nxt.pmds = pmds_img; // RULE20
                     s_nxt.ltr = ltr_img; // RULE21
                     s_nxt.b4k = b4k_img; // RULE22
                  end
                  default: ;
               endcase
            end
         end
         // Stays here until the next reset.
         ST_DONE: ;
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   // State register; every field has a constant reset value.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_r.st <= ST_IDLE;
         s_r.addr <= ADDR_SIG;
         s_r.req <= 1'b0;
         s_r.busy <= 1'b0;
         s_r.done <= 1'b0;
         s_r.valid <= 1'b0;
         s_r.ven <= ID_RESET;
         s_r.dev <= ID_RESET;
         s_r.ssven <= ID_RESET;
         s_r.ssid <= ID_RESET;
         s_r.opt_a <= OPT_RESET;
         // Published identifiers read as defaults until a good image is complete.
         s_r.ven_o <= ID_RESET;
         s_r.dev_o <= ID_RESET;
         s_r.ssven_o <= ID_RESET;
         s_r.ssid_o <= ID_RESET;
         // Published per-port fields start at their hardware defaults.
         s_r.vc <= '0;
         s_r.l0s <= '0;
         s_r.l1 <= '0;
         s_r.noe <= '0;
         s_r.notag <= '0;
         s_r.saf <= '0;
         s_r.ct <= '0;
         s_r.arb <= '0;
         s_r.cred <= '0;
         s_r.inta <= '0;
         s_r.mps <= '0;
         s_r.aspm <= '0;
         s_r.rber <= '0;
         s_r.msi <= '0;
         s_r.par <= '0;
         s_r.pm <= '0;
         s_r.ppnp <= '0;
         s_r.lbn <= '0;
         s_r.frz <= '0;
         s_r.sof <= '0;
         s_r.sdn <= '0;
         s_r.pmds <= '0;
         s_r.ltr <= '0;
         s_r.b4k <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Handshake and status outputs, straight from state flip-flops.
   assign rd_req = s_r.req;
   assign rd_addr = s_r.addr;
   assign load_busy = s_r.busy;
   assign load_done = s_r.done;
   assign image_valid = s_r.valid;
   assign cfg_access_enable = s_r.done; // RULE24

   // Identifiers hold their defaults until a good image has been published.
   assign vendor_id = s_r.ven_o;
   assign device_id = s_r.dev_o;
   assign subsys_vendor_id = s_r.ssven_o;
   assign subsys_id = s_r.ssid_o;

   // Published fields of word 06h, one flip-flop per port bit.
   assign ext_vc_count = s_r.vc;
   assign l0s_exit_latency = s_r.l0s;
   assign l1_exit_latency = s_r.l1;
   assign no_order_egress = s_r.noe;
   assign no_order_tag = s_r.notag;
   assign store_forward = s_r.saf;
   assign cut_through_threshold = s_r.ct;
   assign port_arb_mode = s_r.arb;
   assign credit_update_mode = s_r.cred;
   assign inta_pin = s_r.inta;

   // Published fields of word 0Ch, one flip-flop per port bit.
   assign max_payload_support = s_r.mps;
   assign aspm_support = s_r.aspm;
   assign role_err_report = s_r.rber;
   assign msi_cap_disable = s_r.msi;
   assign compliance_parity_disable = s_r.par;
   assign pm_cap_disable = s_r.pm;
   assign posted_pass_nonposted_enable = s_r.ppnp;
   assign link_bw_notify_cap = s_r.lbn;
   assign ordering_freeze = s_r.frz;
   assign tx_frame_start_latency_select = s_r.sof;
   assign surprise_down_cap = s_r.sdn;
   assign pm_data_select_writable = s_r.pmds;
   assign ltr_cap_enable = s_r.ltr;
   assign boundary_4kb_check = s_r.b4k;

   // Per-port distribution of the two option words.
   // The rd_data terms are only used in the cycle in which word 0Ch is taken.
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      assign vc_img[p] = s_r.opt_a[A_VC]; // RULE2
      assign l0s_img[p*3 +: 3] = s_r.opt_a[A_L0S_LO +: 3]; // RULE3
      assign l1_img[p*3 +: 3] = s_r.opt_a[A_L1_LO +: 3]; // RULE4
      assign noe_img[p] = s_r.opt_a[A_NOORD_EGR]; // RULE5
      assign notag_img[p] = s_r.opt_a[A_NOORD_TAG]; // RULE5
      assign saf_img[p] = s_r.opt_a[A_SAF]; // RULE6
      assign ct_img[p*2 +: 2] = s_r.opt_a[A_CT_LO +: 2]; // RULE6
      assign arb_img[p] = s_r.opt_a[A_ARB]; // RULE7
      assign cred_img[p] = s_r.opt_a[A_CRED]; // RULE7
      assign inta_img[p] = (p >= FIRST_HOST_PORT) ? s_r.opt_a[A_INTA] : 1'b0; // RULE8
      assign mps_img[p*2 +: 2] = rd_data[B_MPS_LO +: 2]; // RULE9
      assign aspm_img[p*2 +: 2] = rd_data[B_ASPM_LO +: 2]; // RULE10
      assign rber_img[p] = rd_data[B_RBER]; // RULE11
      assign msi_img[p] = rd_data[B_MSI_DIS]; // RULE12
      assign par_img[p] = rd_data[B_PAR_DIS]; // RULE13
      assign pm_img[p] = rd_data[B_PM_DIS]; // RULE14
      assign ppnp_img[p] = rd_data[B_PPNP]; // RULE15
      assign lbn_img[p] = (p >= FIRST_HOST_PORT) ? rd_data[B_LBN] : 1'b0; // RULE16
      assign frz_img[p] = rd_data[B_FREEZE]; // RULE17
      assign sof_img[p] = rd_data[B_SOF]; // RULE18
      assign sdn_img[p] = rd_data[B_SDN]; // RULE19
      assign pmds_img[p] = rd_data[B_PMDS]; // RULE20
      assign ltr_img[p] = rd_data[B_LTR]; // RULE21
      assign b4k_img[p] = rd_data[B_4KB]; // RULE22
   end
endmodule
`default_nettype wire

//--- tb/eeprom_model.sv
`default_nettype none
module eeprom_model (
   input wire logic mclk,
   input wire logic rd_req,
   input wire logic [7:0] rd_addr,
   output logic rd_valid,
   output logic [15:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:6];
   int lat = 0;
   // Between answers the data lines show the inverse of the last word, never a stale copy.
   initial begin
      rd_valid = 1'b0;
      rd_data = 16'hffff;
   end
   // Answers each read after lat idle cycles with the word at the requested byte address.
   always @(posedge mclk) begin
      if (rd_req) begin
         repeat (lat) @(posedge mclk);
         #1 rd_valid = 1'b1;
         rd_data = mem[rd_addr[3:1]];
         @(posedge mclk);
         #1 rd_valid = 1'b0;
         rd_data = ~rd_data;
      end
   end
endmodule
`default_nettype wire

//--- tb/eeprom_config_preload_assertions.sv
`default_nettype none
module cfg_preload_checker #(
   parameter logic [15:0] SIGNATURE = cfg_preload_pkg::SIGNATURE_DEFAULT
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic rd_req,
   input wire logic [7:0] rd_addr,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   input wire logic load_busy,
   input wire logic load_done,
   input wire logic image_valid,
   input wire logic cfg_access_enable,
   input wire logic [15:0] vendor_id,
   input wire logic [cfg_preload_pkg::NUM_PORTS-1:0] inta_pin,
   input wire logic [cfg_preload_pkg::NUM_PORTS-1:0] link_bw_notify_cap
);
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_preload_pkg::*;
   // All checks run on the core clock and rest while reset is applied.
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   sequence s_word;
      rd_valid && load_busy;
   endsequence
   sequence s_good_mid;
      s_word ##0 (rd_addr != 8'h0c && (rd_addr != 8'h00 || rd_data == SIGNATURE));
   endsequence
   property p_next_req;
      s_good_mid |-> ##2 (rd_req && rd_addr == $past(rd_addr, 2) + 8'h02);
   endproperty
   property p_bad_sig;
      s_word ##0 (rd_addr == 8'h00 && rd_data != SIGNATURE) |=> (!rd_req) [*3] ##0 (load_done && !image_valid);
   endproperty
   property p_last_word;
      s_word ##0 rd_addr == 8'h0c |=> load_done && image_valid && !load_busy;
   endproperty
   property p_access;
      cfg_access_enable == load_done;
   endproperty
   property p_defaults;
      !image_valid |-> vendor_id == ID_RESET && inta_pin == '0 && link_bw_notify_cap == '0;
   endproperty
   property p_port0;
      inta_pin[0] == 1'b0 && link_bw_notify_cap[0] == 1'b0;
   endproperty
   property p_req_pulse;
      rd_req |=> !rd_req && $stable(rd_addr);
   endproperty
   property p_hold;
      load_done |=> load_done && $stable(image_valid) && $stable(vendor_id);
   endproperty
   property p_valid_done;
      image_valid |-> load_done;
   endproperty
   a_next_req: assert property (p_next_req) else $error("next image word not requested in order");
   a_bad_sig: assert property (p_bad_sig) else $error("bad signature did not end the load");
   a_last_word: assert property (p_last_word) else $error("load not finished after last word");
   a_access: assert property (p_access) else $error("host access not tied to load end");
   a_defaults: assert property (p_defaults) else $error("fields not at default");
   a_port0: assert property (p_port0) else $error("port 0 shows a host port only field");
   a_req_pulse: assert property (p_req_pulse) else $error("read request not a held pulse");
   a_hold: assert property (p_hold) else $error("loaded state changed after load");
   a_valid_done: assert property (p_valid_done) else $error("image valid before done");
endmodule
bind eeprom_config_preload cfg_preload_checker #(.SIGNATURE(SIGNATURE)) u_chk (.*);
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_preload_pkg::*;
   logic mclk, nrst, rd_req, rd_valid, load_busy, load_done, image_valid, cfg_access_enable;
   logic [7:0] rd_addr;
   logic [15:0] rd_data, vendor_id, device_id, subsys_vendor_id, subsys_id;
   logic [NUM_PORTS-1:0] ext_vc_count, no_order_egress, no_order_tag, store_forward, port_arb_mode,
      credit_update_mode, inta_pin, role_err_report, msi_cap_disable, compliance_parity_disable, pm_cap_disable,
      posted_pass_nonposted_enable, link_bw_notify_cap, ordering_freeze, tx_frame_start_latency_select,
      surprise_down_cap, pm_data_select_writable, ltr_cap_enable, boundary_4kb_check;
   logic [NUM_PORTS*3-1:0] l0s_exit_latency, l1_exit_latency;
   logic [NUM_PORTS*2-1:0] cut_through_threshold, max_payload_support, aspm_support;
   int error_cnt = 0;
   int checks_done = 0;
   // Core clock of 40 ns period.
   always #20 mclk = ~mclk;
   eeprom_config_preload DUT (.*);
   eeprom_model EE (.mclk(mclk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Resets, loads an image with ids derived from the option words, and checks defaults meanwhile.
   task automatic load(input logic [15:0] s, input logic [15:0] a, input logic [15:0] b, input int l);
      int n;
      EE.mem = '{s, ~a, ~b, a, a ^ b, a + b, b};
      EE.lat = l;
      n = 0;
      nrst = 1'b0;
      repeat (2) @(posedge mclk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk({cfg_access_enable, image_valid, vendor_id, ext_vc_count, inta_pin}, '0);
      while (load_done !== 1'b1 && n < 300) begin
         @(posedge mclk);
         n++;
      end
      #1;
      checks_done++;
      if (load_done !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: load did not finish in time", $time);
      end
   endtask
   // Compares every loaded field of every port against the option words.
   task automatic chk_all(input logic v, input logic [15:0] a, input logic [15:0] b);
      chk({load_busy, load_done, image_valid, cfg_access_enable}, {2'b01, v, 1'b1});
      chk({vendor_id, device_id, subsys_vendor_id, subsys_id}, {~a, ~b, a ^ b, a + b} & {64{v}});
      for (int p = 0; p < NUM_PORTS; p++) begin
         chk({inta_pin[p], credit_update_mode[p], port_arb_mode[p], cut_through_threshold[p*2+:2], store_forward[p],
            no_order_tag[p], no_order_egress[p], l1_exit_latency[p*3+:3], l0s_exit_latency[p*3+:3], ext_vc_count[p]},
            {a[15] & (p > 0), a[14:8], a[6:0]} & {15{v}});
         chk({boundary_4kb_check[p], ltr_cap_enable[p], pm_data_select_writable[p], surprise_down_cap[p],
            tx_frame_start_latency_select[p], ordering_freeze[p], link_bw_notify_cap[p],
            posted_pass_nonposted_enable[p], pm_cap_disable[p], compliance_parity_disable[p], msi_cap_disable[p],
            role_err_report[p], aspm_support[p*2+:2], max_payload_support[p*2+:2]},
            {b[15:10], b[9] & (p > 0), b[8:0]} & {16{v}});
      end
   endtask
   task automatic stop_test;
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Prompt answers, slow answers with both option words inverted, then a wrong signature.
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      load(SIGNATURE_DEFAULT, 16'hb4d6, 16'h2e9b, 0);
      chk_all(1'b1, 16'hb4d6, 16'h2e9b);
      load(SIGNATURE_DEFAULT, 16'h4b29, 16'hd164, 3);
      chk_all(1'b1, 16'h4b29, 16'hd164);
      load(~SIGNATURE_DEFAULT, 16'hffff, 16'hffff, 1);
      chk_all(1'b0, 16'hffff, 16'hffff);
      // Let the checker finish the windows that the last load opened.
      repeat (4) @(posedge mclk);
      stop_test();
   end
   // Cuts a hang short well after the three loads should have ended.
   initial begin
      #60000;
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
